// file: bench/cfg_host.sv
`timescale 1ns/1ns

module cfg_host (
	// Clock
	input wire logic    clk,
	// Host pins
	output logic        config_clock,
	output logic        config_request_n,
	output logic        user_init_clock,
	output logic [31:0] data,
	// Wire levels
	input wire logic    status_w,
	input wire logic    done_w
);
	// Clocks rest low between frames
	initial begin
		config_clock = 1'b0;
		config_request_n = 1'b1;
		user_init_clock = 1'b0;
		data = 32'h0;
	end

	// 400 ns per pulse; data already stable while low
	task automatic clock_pulses(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge clk);
			config_clock <= 1'b1;
			repeat (4) @(posedge clk);
			config_clock <= 1'b0;
		end
	endtask : clock_pulses

	task automatic restart(output bit ok);
		config_request_n <= 1'b0;
		repeat (40) @(posedge clk);
		config_request_n <= 1'b1;
		ok = 1'b0;
		for (int i = 0; i < 200 && !ok; i++) begin
			@(posedge clk);
			ok = status_w;
		end
		repeat (40) @(posedge clk);
	endtask : restart

	task automatic send_word(input logic [31:0] w, input int r);
		data <= w;
		clock_pulses(r);
	endtask : send_word

	task automatic finish(output bit ok);
		data <= ~data;
		ok = 1'b0;
		for (int i = 0; i < 100 && !ok; i++) begin
			@(posedge clk);
			ok = done_w;
		end
		clock_pulses(2);
	endtask : finish

	task automatic user_clocks(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge clk);
			user_init_clock <= 1'b1;
			repeat (4) @(posedge clk);
			user_init_clock <= 1'b0;
		end
	endtask : user_clocks
endmodule : cfg_host

// file: bench/loader_checker_sva.sv
`timescale 1ns/1ns
`include "fpp_loader_map.svh"

module loader_checker #(
	parameter int unsigned STATUS_LOW_CYCLES = 20,
	parameter int unsigned USER_INIT_PERIODS = 8
) (
	// Clock and reset
	input wire logic                       clk,
	input wire logic                       rst_n,
	// Options
	input wire fpp_loader_pkg::width_sel_t width_sel,
	input wire logic                       user_clock_opt,
	input wire logic                       init_done_opt,
	input wire logic                       dual_purpose_keep,
	// Pins
	input wire logic                       config_request_n,
	input wire logic                       user_init_clock,
	input wire logic                       config_status_n_oe,
	input wire logic                       load_complete_oe,
	input wire logic                       init_complete_oe,
	input wire logic [31:0]                data_oe,
	// Stream and status
	input wire logic                       cfg_word_valid,
	input wire logic                       cfg_word_ready,
	input wire logic [31:0]                cfg_word,
	input wire logic                       user_mode
);
	logic [15:0] stat_cnt_ff, init_cnt_ff, ucnt_ff;
	logic [15:0] nxt_stat_cnt, nxt_init_cnt, nxt_ucnt;
	logic        uclk_ff, nxt_uclk;
	logic [31:0] lane_mask;

	// Status counter counts while status is pulled low and clears once released; init counters clear while load complete is low
	always_comb begin
		nxt_stat_cnt = config_status_n_oe ? stat_cnt_ff + 16'h1 : 16'h0;
		nxt_init_cnt = load_complete_oe ? 16'h0 : init_cnt_ff + 16'h1;
		nxt_ucnt = load_complete_oe ? 16'h0 :
			ucnt_ff + 16'(user_init_clock & ~uclk_ff);
		nxt_uclk = user_init_clock;
		lane_mask = (width_sel == `WIDTH_X8 || width_sel == 2'h3) ?
			32'h0000_00ff :
			(width_sel == `WIDTH_X16) ? 32'h0000_ffff : 32'hffff_ffff;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_cnt_ff <= 16'h0;
			init_cnt_ff <= 16'h0;
			ucnt_ff <= 16'h0;
			uclk_ff <= 1'b0;
		end else begin
			stat_cnt_ff <= nxt_stat_cnt;
			init_cnt_ff <= nxt_init_cnt;
			ucnt_ff <= nxt_ucnt;
			uclk_ff <= nxt_uclk;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_req_resp;
		$fell(config_request_n) |->
			##[1:12] (config_status_n_oe && load_complete_oe);
	endproperty
	a_req_resp: assert property (p_req_resp)
		else $error("status or done late after request");
	property p_por;
		$rose(rst_n) |-> config_status_n_oe [*8];
	endproperty
	a_por: assert property (p_por)
		else $error("status released early after power-up");
	property p_status_min;
		$fell(config_status_n_oe) |-> stat_cnt_ff >= STATUS_LOW_CYCLES;
	endproperty
	a_status_min: assert property (p_status_min)
		else $error("status low pulse too short");
	property p_user_lines;
		user_mode |-> !config_status_n_oe && !load_complete_oe;
	endproperty
	a_user_lines: assert property (p_user_lines)
		else $error("line pulled low in user mode");
	property p_init_osc;
		$rose(user_mode) && !user_clock_opt |->
			init_cnt_ff >= 16'h0dac && init_cnt_ff <= 16'h2224;
	endproperty
	a_init_osc: assert property (p_init_osc)
		else $error("oscillator init time out of range");
	property p_init_user;
		$rose(user_mode) && user_clock_opt |-> ucnt_ff >= USER_INIT_PERIODS;
	endproperty
	a_init_user: assert property (p_init_user)
		else $error("too few user clock periods");
	property p_init_pin;
		init_complete_oe |-> init_done_opt && !user_mode && !load_complete_oe;
	endproperty
	a_init_pin: assert property (p_init_pin)
		else $error("init pin low outside init");
	property p_pins;
		(|data_oe) |-> user_mode && $past(dual_purpose_keep);
	endproperty
	a_pins: assert property (p_pins)
		else $error("data pins driven outside user mode");
	property p_lanes;
		cfg_word_valid |-> (cfg_word & ~lane_mask) == 32'h0;
	endproperty
	a_lanes: assert property (p_lanes)
		else $error("word carries unused lanes");
	property p_hold;
		cfg_word_valid && !cfg_word_ready |=>
			cfg_word_valid && $stable(cfg_word);
	endproperty
	a_hold: assert property (p_hold)
		else $error("stalled word lost or changed");

	c_user: cover property ($rose(user_mode));
	c_done: cover property ($fell(load_complete_oe));
	c_word: cover property (cfg_word_valid && cfg_word_ready);
endmodule : loader_checker

// file: bench/testbench.sv
`timescale 1ns/1ns

bind fast_parallel_config_loader loader_checker #(
	.STATUS_LOW_CYCLES(STATUS_LOW_CYCLES),
	.USER_INIT_PERIODS(USER_INIT_PERIODS)
) chk_u (
	.clk(clk),
	.rst_n(rst_n),
	.width_sel(width_sel),
	.user_clock_opt(user_clock_opt),
	.init_done_opt(init_done_opt),
	.dual_purpose_keep(dual_purpose_keep),
	.config_request_n(config_request_n),
	.user_init_clock(user_init_clock),
	.config_status_n_oe(config_status_n_oe),
	.load_complete_oe(load_complete_oe),
	.init_complete_oe(init_complete_oe),
	.data_oe(data_oe),
	.cfg_word_valid(cfg_word_valid),
	.cfg_word_ready(cfg_word_ready),
	.cfg_word(cfg_word),
	.user_mode(user_mode)
);

module testbench;
	logic clk = 1'b0, rst_n = 1'b0, stall = 1'b0, cfg_word_ready = 1'b0;
	fpp_loader_pkg::width_sel_t width_sel = 2'h0;
	logic decompress_en = 1'b0, security_en = 1'b0, user_clock_opt = 1'b0;
	logic init_done_opt = 1'b0, dual_purpose_keep = 1'b0;
	logic [23:0] image_words = 24'h3;
	logic [31:0] user_pin_out = 32'h0, user_pin_oe = 32'h0;
	logic [31:0] data_out, data_oe, data_in, host_data, cfg_word, user_pin_in;
	logic config_clock, config_request_n, user_init_clock;
	logic config_status_n_oe, load_complete_oe, init_complete_oe;
	logic cfg_word_valid, user_mode, load_error, status_w, done_w;
	logic status_out, done_out, init_out, init_w;
	logic [31:0] got[$];
	int miscompares = 0, checks = 0;

	// Pull-ups on the open-drain lines; shared data pins
	assign status_w = config_status_n_oe ? status_out : 1'b1;
	assign done_w = load_complete_oe ? done_out : 1'b1;
	assign init_w = init_complete_oe ? init_out : 1'b1;
	assign data_in = (data_oe & data_out) | (~data_oe & host_data);

	always #25 clk = ~clk;
	always @(posedge clk) cfg_word_ready <= !stall && !cfg_word_ready;
	always @(posedge clk) begin
		if (cfg_word_valid === 1'b1 && cfg_word_ready === 1'b1) begin
			got.push_back(cfg_word);
		end
	end

	cfg_host host_u (
		.clk(clk),
		.config_clock(config_clock),
		.config_request_n(config_request_n),
		.user_init_clock(user_init_clock),
		.data(host_data),
		.status_w(status_w),
		.done_w(done_w)
	);

	fast_parallel_config_loader #(
		.STATUS_LOW_CYCLES(20),
		.POR_DELAY_CYCLES(10),
		.USER_INIT_PERIODS(8)
	) dut_u (
		.clk(clk),
		.rst_n(rst_n),
		.width_sel(width_sel),
		.decompress_en(decompress_en),
		.security_en(security_en),
		.user_clock_opt(user_clock_opt),
		.init_done_opt(init_done_opt),
		.dual_purpose_keep(dual_purpose_keep),
		.image_words(image_words),
		.config_clock(config_clock),
		.config_request_n(config_request_n),
		.user_init_clock(user_init_clock),
		.data_in(data_in),
		.data_out(data_out),
		.data_oe(data_oe),
		.config_status_n_in(status_w),
		.config_status_n_out(status_out),
		.config_status_n_oe(config_status_n_oe),
		.load_complete_out(done_out),
		.load_complete_oe(load_complete_oe),
		.init_complete_out(init_out),
		.init_complete_oe(init_complete_oe),
		.cfg_word_valid(cfg_word_valid),
		.cfg_word_ready(cfg_word_ready),
		.cfg_word(cfg_word),
		.user_pin_out(user_pin_out),
		.user_pin_oe(user_pin_oe),
		.user_pin_in(user_pin_in),
		.user_mode(user_mode),
		.load_error(load_error)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : check

	function automatic int ratio(input int w, input bit d, input bit s);
		if (w == 3) return 1;
		if (w == 0) return d ? 2 : 1;
		if (w == 1) return d ? 4 : (s ? 2 : 1);
		return d ? 8 : (s ? 4 : 1);
	endfunction : ratio

	task automatic end_of_test();
		if (miscompares == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test

	// Receiver stalls so the buffer fills and the next capture overflows
	task automatic overflow();
		bit ok;
		stall <= 1'b1;
		width_sel <= 2'h2;
		image_words <= 24'h8;
		host_u.restart(ok);
		for (int i = 0; i < 4; i++) host_u.send_word(32'h1234_5670 + i, 1);
		repeat (4) @(posedge clk);
		check(32'(load_error), 32'h1);
		check(32'(status_w), 32'h0);
		stall <= 1'b0;
		repeat (8) @(posedge clk);
		check(got[0], 32'h1234_5670);
		check(got[1], 32'h1234_5671);
	endtask : overflow

	task automatic user_checks();
		check(32'({status_w, done_w}), 32'h3);
		dual_purpose_keep <= 1'b1;
		user_pin_oe <= 32'hffff_0f0f;
		user_pin_out <= 32'h5a5a_c3c3;
		repeat (4) @(posedge clk);
		check(data_oe, 32'hffff_0f0f);
		check(data_out & data_oe, 32'h5a5a_0303);
		check(user_pin_in, (host_data & 32'h0000_f0f0) | 32'h5a5a_0303);
		dual_purpose_keep <= 1'b0;
		host_u.send_word(32'h0000_0001, 1);
		check(data_oe, 32'h0);
		check(32'(got.size()), 32'h3);
	endtask : user_checks

	task automatic load(input int w, input bit d, input bit s, input bit uc);
		logic [31:0] m;
		bit          ok;
		int          r;
		r = ratio(w, d, s);
		m = (w == 0 || w == 3) ? 32'h0000_00ff :
			(w == 1) ? 32'h0000_ffff : '1;
		width_sel <= 2'(w);
		decompress_en <= d;
		security_en <= s;
		user_clock_opt <= uc;
		init_done_opt <= s;
		image_words <= 24'h3;
		got.delete();
		host_u.restart(ok);
		check(32'(ok), 32'h1);
		check(32'({load_error, user_mode}), 32'h0);
		for (int i = 0; i < 3; i++) begin
			host_u.send_word(32'h9a5c_3e71 + i, r);
			if (i < 2) check(32'(load_complete_oe), 32'h1);
		end
		host_u.finish(ok);
		check(32'(ok), 32'h1);
		repeat (8) @(posedge clk);
		check(32'(init_complete_oe), 32'(s));
		check(32'(init_w), 32'(!s));
		if (uc) host_u.user_clocks(8);
		for (int i = 0; i < 9000 && user_mode !== 1'b1; i++) @(posedge clk);
		check(32'(user_mode), 32'h1);
		check(32'(got.size()), 32'h3);
		foreach (got[i]) check(got[i], (32'h9a5c_3e71 + i) & m);
		user_checks();
	endtask : load

	initial begin
		#2_000_000;
		miscompares++;
		end_of_test();
	end

	initial begin
		repeat (8) @(posedge clk);
		check(32'({config_status_n_oe, load_complete_oe}), 32'h3);
		rst_n <= 1'b1;
		overflow();
		for (int k = 0; k < 12; k++) load(k / 4, k[1], k[0], 1'b1);
		load(2, 1'b0, 1'b1, 1'b0);
		// Spare width code falls back to x8 lanes at ratio one
		load(3, 1'b1, 1'b1, 1'b1);
		end_of_test();
	end
endmodule : testbench

// file: verilog/fast_parallel_config_loader.sv
// Overview of operation
// - x8 width: ratio 1 without decompression, 2 with it.
// - x16 width: ratio 1 plain, 2 with security only, 4 with decompression.
// - x32 width: ratio 1 plain, 4 with security only, 8 with decompression.
// - x8 uses lines 7..0, x16 uses 15..0, x32 all lines.
// - User mode: request, status, done high; request low restarts loading.
// - After power-up status stays low for the power-on delay.
// - Load complete low until the whole image arrived, then released.
// - Configuration clock ignored once two falling edges follow load complete; host keeps it defined.
// - With the option loaded, init complete low until initialization ends.
// - Request low drives load complete and status low within 600 ns.
// - Status low 268 to 1506 us; rises within 1506 us of request high.
// - Internal oscillator: user mode 175 to 437 us after load complete.
// - User init clock: user mode after 8576 user clock periods.
// - Each data word is captured on a rising configuration clock edge.
// - After loading the data lines become user pins per dual-purpose setting.
`timescale 1ns/1ns
`include "fpp_loader_map.svh"

module fast_parallel_config_loader #(
	parameter int unsigned STATUS_LOW_CYCLES = `STATUS_LOW_CYCLES,
	parameter int unsigned POR_DELAY_CYCLES  = `POR_DELAY_CYCLES,
	parameter int unsigned USER_INIT_PERIODS = `USER_INIT_PERIODS
) (
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	// Configuration options, from logic on clk
	input  wire fpp_loader_pkg::width_sel_t      width_sel,
	input  wire logic                            decompress_en,
	input  wire logic                            security_en,
	input  wire logic                            user_clock_opt,
	input  wire logic                            init_done_opt,
	input  wire logic                            dual_purpose_keep,
	input  wire logic [23:0]                     image_words,
	// Host pins
	input  wire logic                            config_clock,
	input  wire logic                            config_request_n,
	input  wire logic                            user_init_clock,
	input  wire logic [31:0]                     data_in,
	output logic [31:0]                          data_out,
	output logic [31:0]                          data_oe,
	input  wire logic                            config_status_n_in,
	output logic                                 config_status_n_out,
	output logic                                 config_status_n_oe,
	output logic                                 load_complete_out,
	output logic                                 load_complete_oe,
	output logic                                 init_complete_out,
	output logic                                 init_complete_oe,
	// Loaded words toward the core
	output logic                                 cfg_word_valid,
	input  wire logic                            cfg_word_ready,
	output logic [31:0]                          cfg_word,
	// User side of the data pins
	input  wire logic [31:0]                     user_pin_out,
	input  wire logic [31:0]                     user_pin_oe,
	output logic [31:0]                          user_pin_in,
	// Status
	output logic                                 user_mode,
	output logic                                 load_error
);

	logic [2:0]  clk_sync_ff;
	logic [1:0]  req_sync_ff;
	logic [1:0]  stat_sync_ff;
	logic [2:0]  uclk_sync_ff;
	logic [31:0] data_s1_ff;
	logic [31:0] data_s2_ff;
	logic        clk_rise;
	logic        clk_fall;
	logic        uclk_rise;
	logic        req_low;
	logic        stat_low;

	fpp_loader_pkg::load_state_t state_ff;
	fpp_loader_pkg::load_state_t nxt_state;
	logic [15:0] timer_ff;
	logic [15:0] nxt_timer;
	logic [3:0]  ratio_ff;
	logic [3:0]  nxt_ratio;
	logic [3:0]  phase_ff;
	logic [3:0]  nxt_phase;
	logic [23:0] words_ff;
	logic [23:0] nxt_words;
	logic [1:0]  falls_ff;
	logic [1:0]  nxt_falls;
	logic [31:0] lane_mask;
	logic        capture;
	logic        buf_in_ready;

	logic        status_oe_ff;
	logic        nxt_status_oe;
	logic        done_oe_ff;
	logic        nxt_done_oe;
	logic        init_oe_ff;
	logic        nxt_init_oe;
	logic        user_mode_ff;
	logic        nxt_user_mode;
	logic        error_ff;
	logic        nxt_error;
	logic [31:0] data_out_ff;
	logic [31:0] nxt_data_out;
	logic [31:0] data_oe_ff;
	logic [31:0] nxt_data_oe;

	function automatic logic [3:0] ratio_of(
		input fpp_loader_pkg::width_sel_t w,
		input logic                       dec,
		input logic                       sec
	);
		logic [3:0] r;
		r = `RATIO_ONE;
		case (w)
			`WIDTH_X8: begin
				r = dec ? `RATIO_TWO : `RATIO_ONE;
			end
			`WIDTH_X16: begin
				if (dec) begin
					r = `RATIO_FOUR;
				end else begin
					r = sec ? `RATIO_TWO : `RATIO_ONE;
				end
			end
			`WIDTH_X32: begin
				if (dec) begin
					r = `RATIO_EIGHT;
				end else begin
					r = sec ? `RATIO_FOUR : `RATIO_ONE;
				end
			end
			default: begin
				r = `RATIO_ONE;
			end
		endcase
		return r;
	endfunction : ratio_of

	function automatic logic lane_on(
		input fpp_loader_pkg::width_sel_t w,
		input int                         lane
	);
		logic on;
		on = 1'b0;
		case (w)
			`WIDTH_X8:  on = (lane == 0);
			`WIDTH_X16: on = (lane < 2);
			`WIDTH_X32: on = 1'b1;
			default:    on = (lane == 0);
		endcase
		return on;
	endfunction : lane_on

	// Unused byte lanes of narrow widths read as zero
	for (genvar g = 0; g < 4; g++) begin : g_lane
		assign lane_mask[g*8 +: 8] = {8{lane_on(width_sel, g)}};
	end

	// Two flops on every pin before any logic reads it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_sync_ff  <= 3'h0;
			req_sync_ff  <= 2'h3;
			stat_sync_ff <= 2'h0;
			uclk_sync_ff <= 3'h0;
			data_s1_ff   <= 32'h0;
			data_s2_ff   <= 32'h0;
		end else begin
			clk_sync_ff  <= {clk_sync_ff[1:0], config_clock};
			req_sync_ff  <= {req_sync_ff[0], config_request_n};
			stat_sync_ff <= {stat_sync_ff[0], config_status_n_in};
			uclk_sync_ff <= {uclk_sync_ff[1:0], user_init_clock};
			data_s1_ff   <= data_in;
			data_s2_ff   <= data_s1_ff;
		end
	end

	// Edges taken from the second and third flops only
	assign clk_rise  = clk_sync_ff[1] & ~clk_sync_ff[2];
	assign clk_fall  = ~clk_sync_ff[1] & clk_sync_ff[2];
	assign uclk_rise = uclk_sync_ff[1] & ~uclk_sync_ff[2];
	assign req_low   = ~req_sync_ff[1];
	assign stat_low  = ~stat_sync_ff[1];

	// Only the first clock of each group of r carries a new word
	assign capture = (state_ff == fpp_loader_pkg::ST_LOAD) & clk_rise &
		(phase_ff == 4'h0) & ~stat_low;

	always_comb begin
		nxt_state     = state_ff;
		nxt_timer     = timer_ff;
		nxt_ratio     = ratio_ff;
		nxt_phase     = phase_ff;
		nxt_words     = words_ff;
		nxt_falls     = falls_ff;
		nxt_status_oe = status_oe_ff;
		nxt_done_oe   = done_oe_ff;
		nxt_init_oe   = init_oe_ff;
		nxt_user_mode = user_mode_ff;
		nxt_error     = error_ff;
		case (state_ff)
			fpp_loader_pkg::ST_POR: begin
				nxt_status_oe = 1'b1;
				nxt_done_oe   = 1'b1;
				nxt_timer     = timer_ff + 16'h1;
				if (timer_ff >= 16'(POR_DELAY_CYCLES - 1)) begin
					nxt_state = fpp_loader_pkg::ST_RESET;
					nxt_timer = 16'h0;
				end
			end
			fpp_loader_pkg::ST_RESET: begin
				nxt_status_oe = 1'b1;
				nxt_done_oe   = 1'b1;
				nxt_user_mode = 1'b0;
				nxt_init_oe   = 1'b0;
				nxt_error     = 1'b0;
				nxt_phase     = 4'h0;
				nxt_words     = 24'h0;
				nxt_falls     = 2'h0;
				if (timer_ff != 16'hffff) begin
					nxt_timer = timer_ff + 16'h1;
				end
				// Rise once both the least low time and request high hold
				if (!req_low &&
				    timer_ff >= 16'(STATUS_LOW_CYCLES - 1)) begin
					nxt_state     = fpp_loader_pkg::ST_LOAD;
					nxt_status_oe = 1'b0;
					nxt_ratio     = ratio_of(width_sel, decompress_en,
						security_en);
				end
			end
			fpp_loader_pkg::ST_LOAD: begin
				if (clk_rise && !stat_low) begin
					nxt_phase = (phase_ff == ratio_ff - 4'h1) ?
						4'h0 : phase_ff + 4'h1;
				end
				if (capture) begin
					nxt_words = words_ff + 24'h1;
				end
				// A word the buffer cannot take is an error on status
				if (capture && !buf_in_ready) begin
					nxt_state     = fpp_loader_pkg::ST_ERROR;
					nxt_status_oe = 1'b1;
					nxt_error     = 1'b1;
				end else if (words_ff == image_words &&
				             phase_ff == 4'h0) begin
					nxt_state   = fpp_loader_pkg::ST_DONE_WAIT;
					nxt_done_oe = 1'b0;
				end
			end
			fpp_loader_pkg::ST_DONE_WAIT: begin
				if (clk_fall) begin
					nxt_falls = falls_ff + 2'h1;
				end
				if (falls_ff == `DONE_FALL_EDGES) begin
					nxt_state   = fpp_loader_pkg::ST_INIT;
					nxt_timer   = 16'h0;
					nxt_init_oe = init_done_opt;
				end
			end
			fpp_loader_pkg::ST_INIT: begin
				// Clock pin no longer looked at from here on
				if (user_clock_opt) begin
					if (uclk_rise) begin
						nxt_timer = timer_ff + 16'h1;
					end
					if (timer_ff >= 16'(USER_INIT_PERIODS)) begin
						nxt_state = fpp_loader_pkg::ST_USER;
					end
				end else begin
					nxt_timer = timer_ff + 16'h1;
					if (timer_ff >= 16'(`INIT_OSC_CYCLES - 1)) begin
						nxt_state = fpp_loader_pkg::ST_USER;
					end
				end
				if (nxt_state == fpp_loader_pkg::ST_USER) begin
					nxt_init_oe   = 1'b0;
					nxt_user_mode = 1'b1;
				end
			end
			fpp_loader_pkg::ST_USER: begin
				nxt_user_mode = 1'b1;
			end
			fpp_loader_pkg::ST_ERROR: begin
				nxt_status_oe = 1'b1;
			end
			default: begin
				nxt_state = fpp_loader_pkg::ST_POR;
			end
		endcase
		// Request low restarts from any state but the power-on hold
		if (req_low && state_ff != fpp_loader_pkg::ST_POR) begin
			nxt_state     = fpp_loader_pkg::ST_RESET;
			nxt_status_oe = 1'b1;
			nxt_done_oe   = 1'b1;
			nxt_init_oe   = 1'b0;
			nxt_user_mode = 1'b0;
			if (state_ff != fpp_loader_pkg::ST_RESET) begin
				nxt_timer = 16'h0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff     <= fpp_loader_pkg::ST_POR;
			timer_ff     <= 16'h0;
			ratio_ff     <= `RATIO_ONE;
			phase_ff     <= 4'h0;
			words_ff     <= 24'h0;
			falls_ff     <= 2'h0;
			status_oe_ff <= 1'b1;
			done_oe_ff   <= 1'b1;
			init_oe_ff   <= 1'b0;
			user_mode_ff <= 1'b0;
			error_ff     <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			timer_ff     <= nxt_timer;
			ratio_ff     <= nxt_ratio;
			phase_ff     <= nxt_phase;
			words_ff     <= nxt_words;
			falls_ff     <= nxt_falls;
			status_oe_ff <= nxt_status_oe;
			done_oe_ff   <= nxt_done_oe;
			init_oe_ff   <= nxt_init_oe;
			user_mode_ff <= nxt_user_mode;
			error_ff     <= nxt_error;
		end
	end

	// Data pins hand over to user logic only in user mode
	always_comb begin
		nxt_data_out = 32'h0;
		nxt_data_oe  = 32'h0;
		if (nxt_user_mode && dual_purpose_keep) begin
			nxt_data_out = user_pin_out;
			nxt_data_oe  = user_pin_oe;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out_ff <= 32'h0;
			data_oe_ff  <= 32'h0;
		end else begin
			data_out_ff <= nxt_data_out;
			data_oe_ff  <= nxt_data_oe;
		end
	end

	word_buffer u_buf (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (capture),
		.in_ready  (buf_in_ready),
		.in_data   (data_s2_ff & lane_mask),
		.out_valid (cfg_word_valid),
		.out_ready (cfg_word_ready),
		.out_data  (cfg_word)
	);

	// Open-drain lines only ever pull low
	assign config_status_n_out = 1'b0;
	assign load_complete_out   = 1'b0;
	assign init_complete_out   = 1'b0;
	assign config_status_n_oe  = status_oe_ff;
	assign load_complete_oe    = done_oe_ff;
	assign init_complete_oe    = init_oe_ff;
	assign data_out            = data_out_ff;
	assign data_oe             = data_oe_ff;
	assign user_pin_in         = data_s2_ff;
	assign user_mode           = user_mode_ff;
	assign load_error          = error_ff;

endmodule : fast_parallel_config_loader

// file: verilog/fpp_loader_map.svh
`ifndef FPP_LOADER_MAP_SVH
`define FPP_LOADER_MAP_SVH

// Clock rate of clk
`define CLK_MHZ              20

// Width select codes
`define WIDTH_X8             2'h0
`define WIDTH_X16            2'h1
`define WIDTH_X32            2'h2

// Clock-to-word ratios
`define RATIO_ONE            4'h1
`define RATIO_TWO            4'h2
`define RATIO_FOUR           4'h4
`define RATIO_EIGHT          4'h8

// Status low pulse, least time
`define STATUS_LOW_MIN_US    268
`define STATUS_LOW_CYCLES    (`STATUS_LOW_MIN_US * `CLK_MHZ)

// Power-on hold of status
`define POR_DELAY_US         100
`define POR_DELAY_CYCLES     (`POR_DELAY_US * `CLK_MHZ)

// Initialization on the internal oscillator
`define INIT_OSC_MIN_US      175
`define INIT_OSC_CYCLES      (`INIT_OSC_MIN_US * `CLK_MHZ)

// Initialization on the user clock
`define USER_INIT_PERIODS    8576

// Falling edges after load complete
`define DONE_FALL_EDGES      2'h2

// Request low to status and load-complete low, longest time
`define REQ_RESP_MAX_NS      600
`define REQ_RESP_MAX_CYCLES  ((`REQ_RESP_MAX_NS * `CLK_MHZ) / 1000)

// Word buffer
`define BUF_WIDTH            32

`endif

// file: verilog/fpp_loader_pkg.sv
package fpp_loader_pkg;

	typedef enum logic [2:0] {
		ST_POR       = 3'h0,
		ST_RESET     = 3'h1,
		ST_LOAD      = 3'h2,
		ST_DONE_WAIT = 3'h3,
		ST_INIT      = 3'h4,
		ST_USER      = 3'h5,
		ST_ERROR     = 3'h6
	} load_state_t;

	typedef logic [1:0] width_sel_t;

endpackage : fpp_loader_pkg

// file: verilog/word_buffer.sv
`timescale 1ns/1ns
`include "fpp_loader_map.svh"

module word_buffer (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Filling side
	input  wire logic                   in_valid,
	output logic                        in_ready,
	input  wire logic [`BUF_WIDTH-1:0]  in_data,
	// Draining side
	output logic                        out_valid,
	input  wire logic                   out_ready,
	output logic [`BUF_WIDTH-1:0]       out_data
);

	logic                  head_v_ff;
	logic                  nxt_head_v;
	logic [`BUF_WIDTH-1:0] head_d_ff;
	logic [`BUF_WIDTH-1:0] nxt_head_d;
	logic                  spare_v_ff;
	logic                  nxt_spare_v;
	logic [`BUF_WIDTH-1:0] spare_d_ff;
	logic [`BUF_WIDTH-1:0] nxt_spare_d;
	logic                  push;
	logic                  pop;

	// Ready from a flop: full only when the spare slot holds a word
	assign in_ready  = ~spare_v_ff;
	assign out_valid = head_v_ff;
	assign out_data  = head_d_ff;
	assign push      = in_valid & ~spare_v_ff;
	assign pop       = head_v_ff & out_ready;

	always_comb begin
		nxt_head_v  = head_v_ff;
		nxt_head_d  = head_d_ff;
		nxt_spare_v = spare_v_ff;
		nxt_spare_d = spare_d_ff;
		if (pop) begin
			nxt_head_v  = spare_v_ff;
			nxt_head_d  = spare_d_ff;
			nxt_spare_v = 1'b0;
		end
		if (push) begin
			if (!nxt_head_v) begin
				nxt_head_v = 1'b1;
				nxt_head_d = in_data;
			end else begin
				nxt_spare_v = 1'b1;
				nxt_spare_d = in_data;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			head_v_ff  <= 1'b0;
			head_d_ff  <= '0;
			spare_v_ff <= 1'b0;
			spare_d_ff <= '0;
		end else begin
			head_v_ff  <= nxt_head_v;
			head_d_ff  <= nxt_head_d;
			spare_v_ff <= nxt_spare_v;
			spare_d_ff <= nxt_spare_d;
		end
	end

endmodule : word_buffer
